// ==== src/adcr_pkg.sv ====
package adcr_pkg;

  // register addresses as seen in the instruction byte
  localparam logic [4:0] ADDR_RES_LO   = 5'h00;
  localparam logic [4:0] ADDR_RES_HI   = 5'h01;
  localparam logic [4:0] ADDR_LIMITS   = 5'h02;
  localparam logic [4:0] ADDR_CTRL     = 5'h03;
  localparam logic [4:0] ADDR_USER_END = 5'h0A;  // first reserved address

  // reset value of every register and the writable bits of the control register
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h2F;

  // instruction byte fields
  localparam int         INSTR_CONV_BIT = 7;
  localparam int         INSTR_READ_BIT = 6;
  localparam int         ADDR_MSB       = 4;

  // serial framing and conversion start timing
  localparam logic [2:0] BYTE_LAST   = 3'h7;
  localparam logic [1:0] START_FALLS = 2'h2;  // divided-clock falling edges before start

  // readback modes
  localparam logic [1:0] RDBK_CMD      = 2'h0;
  localparam logic [1:0] RDBK_MS_FIRST = 2'h1;
  localparam logic [1:0] RDBK_LS_FIRST = 2'h2;
  localparam logic [1:0] RDBK_MS_ONLY  = 2'h3;

  // result layout
  localparam int         RES_MSB    = 13;
  localparam int         RES_LO_MSB = 5;
  localparam int         RES_HI_LSB = 6;

  // converter control register layout
  typedef struct packed {
    logic       rsv_hi;
    logic       rsv_mid;
    logic       straight_binary_select;
    logic       rsv_lo;
    logic [1:0] readback_mode_select;
    logic [1:0] clock_divisor_select;
  } adcr_ctrl_s;

  // one finished conversion as delivered by the converter core
  typedef struct packed {
    logic [13:0] conv_result_bits;
    logic [5:0]  amp_limit_flag_bits;
  } adcr_sample_s;

  typedef enum logic [1:0] {PH_INSTR, PH_WDATA, PH_RDATA, PH_RBK} adcr_phase_e;
  typedef enum logic [1:0] {CV_IDLE, CV_WAIT, CV_BUSY} adcr_conv_e;

endpackage

// ==== src/adcr_clkdiv.sv ====
module adcr_clkdiv (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       conv_clk_pin,
  input  wire logic [1:0] div_sel,
  output logic            div_clk_r,
  output logic            div_fall_r
);
  logic       conv_clk_s1_r;
  logic       conv_clk_s2_r;
  logic       conv_clk_s3_r;
  logic [2:0] cnt_r;
  logic       div_clk_nxt;

  // two-stage synchroniser, third stage only for edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_clk_s1_r <= 1'b0;
      conv_clk_s2_r <= 1'b0;
      conv_clk_s3_r <= 1'b0;
    end else begin
      conv_clk_s1_r <= conv_clk_pin;
      conv_clk_s2_r <= conv_clk_s1_r;
      conv_clk_s3_r <= conv_clk_s2_r;
    end
  end

  // ripple count of input clock rises; bit n toggles at input clock / 2^(n+1)
  always_ff @(posedge clk) begin
    if (!rst_n) cnt_r <= 3'h0;
    else if (conv_clk_s2_r && !conv_clk_s3_r) cnt_r <= cnt_r + 3'h1;
  end

  // divisor select: 1, 2, 4, 8
  always_comb begin
    case (div_sel)
      2'h0:    div_clk_nxt = conv_clk_s2_r;
      2'h1:    div_clk_nxt = cnt_r[0];
      2'h2:    div_clk_nxt = cnt_r[1];
      default: div_clk_nxt = cnt_r[2];
    endcase
  end

  // divided clock out and its falling-edge strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_clk_r  <= 1'b0;
      div_fall_r <= 1'b0;
    end else begin
      div_clk_r  <= div_clk_nxt;
      div_fall_r <= div_clk_r && !div_clk_nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  // both of the last two selects must be divide-by-8, else a select change moves the clock
  chk_div_by_eight: assert property (
    ($past(div_sel) == 2'h3 && $past(div_sel, 2) == 2'h3 && $changed(div_clk_r))
      |-> $past(cnt_r[2]) != $past(cnt_r[2], 2))
    else $error("divided clock moved without its counter bit");
endmodule

// ==== src/adcr_regs.sv ====
// Operation
// - reset clears every register bit to zero
// - result bytes at 0,1 read-only, writes ignored
// - addr0: result 5:0 high, bit1 zero, over-range
// - addr1 holds result bits 13 to 6
// - bit order follows lsb-first setting
// - over-range set when any limit exceeded
// - addr2 read-only limit flags, top two zero
// - each limit flag reads one when exceeded
// - control bit5 picks binary or twos complement
// - control bits 3:2 pick readback mode
// - modes 1-3 return result without read instruction
// - divided clock is input clock over 1,2,4,8
// - ten user registers, remaining addresses reserved
// - conversion starts second divided falling edge after command
// - read data sampled at data byte start
module adcr_regs (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 din,
  input  wire logic                 lsb_first,
  input  wire logic                 conversion_clock_in,
  input  wire logic                 conv_done,
  input  wire adcr_pkg::adcr_sample_s conv_sample,
  output logic                      dout,
  output logic                      dout_oe,
  output logic                      divided_converter_clock,
  output logic                      conv_start,
  output logic                      convert_busy_bit
);
  logic                  sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic                  cs_s1_r, cs_s2_r, cs_s3_r;
  logic                  din_s1_r, din_s2_r;
  logic                  sclk_rise, cs_start, cs_act;
  adcr_pkg::adcr_phase_e phase_r;
  logic [2:0]            bit_cnt_r;
  logic [7:0]            rx_sr_r, tx_sr_r, rx_byte;
  logic [4:0]            addr_r;
  logic                  two_left_r;
  logic                  wr_r, cmd_conv_r;
  logic [7:0]            wdata_r, rd_data, res_lo, res_hi;
  adcr_pkg::adcr_ctrl_s  ctrl_r;
  logic [13:0]           result_r;
  logic [5:0]            flags_r;
  logic                  over_range_r, rb_pend_r, div_fall, latch;
  adcr_pkg::adcr_conv_e  cv_r;
  logic [1:0]            falls_r;

  // shift one serial bit into a byte in the chosen order
  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic b, input logic lsb);
    shift_in = lsb ? {b, sr[7:1]} : {sr[6:0], b};
  endfunction

  // pick the bit to drive for position n of a byte
  function automatic logic pick_bit(input logic [7:0] sr, input logic [2:0] n, input logic lsb);
    pick_bit = lsb ? sr[n] : sr[3'h7 - n];
  endfunction

  // pins cross in through two flops; third stage only feeds edge detection
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= 3'h0;
      {cs_s1_r, cs_s2_r, cs_s3_r}       <= 3'h7;
      {din_s1_r, din_s2_r}              <= 2'h0;
    end else begin
      {sclk_s1_r, sclk_s2_r, sclk_s3_r} <= {sclk, sclk_s1_r, sclk_s2_r};
      {cs_s1_r, cs_s2_r, cs_s3_r}       <= {cs_n, cs_s1_r, cs_s2_r};
      {din_s1_r, din_s2_r}              <= {din, din_s1_r};
    end
  end

  assign sclk_rise = sclk_s2_r && !sclk_s3_r;  // rising edge is the active edge
  assign cs_act    = !cs_s2_r;
  assign cs_start  = !cs_s2_r && cs_s3_r;
  assign rx_byte   = shift_in(rx_sr_r, din_s2_r, lsb_first);

  // register layouts
  assign res_lo = {result_r[adcr_pkg::RES_LO_MSB:0], 1'b0, over_range_r};
  assign res_hi = result_r[adcr_pkg::RES_MSB:adcr_pkg::RES_HI_LSB];

  // read mux; addresses of other blocks and reserved space read zero
  always_comb begin
    case (addr_r)
      adcr_pkg::ADDR_RES_LO: rd_data = res_lo;
      adcr_pkg::ADDR_RES_HI: rd_data = res_hi;
      adcr_pkg::ADDR_LIMITS: rd_data = {2'h0, flags_r};
      adcr_pkg::ADDR_CTRL:   rd_data = ctrl_r;
      default:               rd_data = adcr_pkg::REG_RESET;
    endcase
  end

  // serial frame engine; cs high aborts the frame
  always_ff @(posedge clk) begin
    if (!rst_n || !cs_act) begin
      phase_r    <= adcr_pkg::PH_INSTR;
      bit_cnt_r  <= 3'h0;
      rx_sr_r    <= 8'h00;
      tx_sr_r    <= 8'h00;
      addr_r     <= 5'h00;
      two_left_r <= 1'b0;
      wr_r       <= 1'b0;
      cmd_conv_r <= 1'b0;
      wdata_r    <= 8'h00;
    end else begin
      wr_r       <= 1'b0;
      cmd_conv_r <= 1'b0;
      if (cs_start && rb_pend_r) begin
        // automatic readback replaces the instruction byte
        phase_r    <= adcr_pkg::PH_RBK;
        two_left_r <= ctrl_r.readback_mode_select != adcr_pkg::RDBK_MS_ONLY;
        tx_sr_r    <= ctrl_r.readback_mode_select == adcr_pkg::RDBK_LS_FIRST ? res_lo : res_hi;
      end else if (sclk_rise) begin
        rx_sr_r   <= rx_byte;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == adcr_pkg::BYTE_LAST) begin
          case (phase_r)
            adcr_pkg::PH_INSTR: begin
              addr_r <= rx_byte[adcr_pkg::ADDR_MSB:0];
              if (rx_byte[adcr_pkg::INSTR_CONV_BIT]) begin
                cmd_conv_r <= 1'b1;
              end else if (rx_byte[adcr_pkg::INSTR_READ_BIT]) begin
                phase_r <= adcr_pkg::PH_RDATA;
                two_left_r <= 1'b1;  // marks the data snapshot as still due
              end else begin
                phase_r <= adcr_pkg::PH_WDATA;
              end
            end
            adcr_pkg::PH_WDATA: begin
              wr_r    <= 1'b1;
              wdata_r <= rx_byte;
              phase_r <= adcr_pkg::PH_INSTR;
            end
            adcr_pkg::PH_RBK: begin
              two_left_r <= 1'b0;
              if (two_left_r) begin
                tx_sr_r <= ctrl_r.readback_mode_select == adcr_pkg::RDBK_LS_FIRST ? res_hi
                                                                                 : res_lo;
              end else begin
                phase_r <= adcr_pkg::PH_INSTR;
              end
            end
            default: phase_r <= adcr_pkg::PH_INSTR;
          endcase
        end
      end else if (phase_r == adcr_pkg::PH_RDATA && two_left_r) begin
        // snapshot once the instruction is in, before the first data edge
        tx_sr_r    <= rd_data;
        two_left_r <= 1'b0;
      end
    end
  end

  // data out changes after an active edge, or after cs falls for an automatic readback; released while cs is high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout    <= 1'b0;
      dout_oe <= 1'b0;
    end else begin
      dout_oe <= cs_act;
      if (phase_r == adcr_pkg::PH_RDATA || phase_r == adcr_pkg::PH_RBK) begin
        dout <= pick_bit(tx_sr_r, bit_cnt_r, lsb_first);
      end else begin
        dout <= 1'b0;
      end
    end
  end

  // control register; reserved bits are masked so they always read zero
  always_ff @(posedge clk) begin
    if (!rst_n) ctrl_r <= adcr_pkg::REG_RESET;
    else if (wr_r && addr_r == adcr_pkg::ADDR_CTRL) ctrl_r <= wdata_r & adcr_pkg::CTRL_WMASK;
  end

  adcr_clkdiv u_div (
    .clk         (clk),
    .rst_n       (rst_n),
    .conv_clk_pin (conversion_clock_in),
    .div_sel      (ctrl_r.clock_divisor_select),
    .div_clk_r    (divided_converter_clock),
    .div_fall_r   (div_fall)
  );

  assign latch = cv_r == adcr_pkg::CV_BUSY && conv_done;

  // conversion sequencing: wait two divided falling edges, then busy until done
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cv_r       <= adcr_pkg::CV_IDLE;
      falls_r    <= 2'h0;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (cv_r)
        adcr_pkg::CV_IDLE: if (cmd_conv_r) begin
          cv_r    <= adcr_pkg::CV_WAIT;
          falls_r <= 2'h0;
        end
        adcr_pkg::CV_WAIT: if (div_fall) begin
          falls_r <= falls_r + 2'h1;
          if (falls_r + 2'h1 == adcr_pkg::START_FALLS) begin
            conv_start <= 1'b1;
            cv_r       <= adcr_pkg::CV_BUSY;
          end
        end
        adcr_pkg::CV_BUSY: if (conv_done) cv_r <= adcr_pkg::CV_IDLE;
        default: cv_r <= adcr_pkg::CV_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) convert_busy_bit <= 1'b0;
    else convert_busy_bit <= cv_r != adcr_pkg::CV_IDLE;
  end

  // result, over-range and limit flags change together; writes never reach them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result_r <= 14'h0000;
      flags_r  <= 6'h00;
      over_range_r <= 1'b0;
    end else if (latch) begin
      result_r <= {conv_sample.conv_result_bits[adcr_pkg::RES_MSB] ^ ctrl_r.straight_binary_select,
                   conv_sample.conv_result_bits[adcr_pkg::RES_MSB-1:0]};
      flags_r  <= conv_sample.amp_limit_flag_bits;
      over_range_r <= |conv_sample.amp_limit_flag_bits;
    end
  end

  // readback request; a new result wins over the frame that consumes the old one
  always_ff @(posedge clk) begin
    if (!rst_n) rb_pend_r <= 1'b0;
    else if (latch && ctrl_r.readback_mode_select != adcr_pkg::RDBK_CMD)
      rb_pend_r <= 1'b1;
    else if (cs_start) rb_pend_r <= 1'b0;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_reset_clears: assert property (disable iff (1'b0)
    !rst_n |=> ctrl_r == 8'h00 && result_r == 14'h0000 && flags_r == 6'h00 && !over_range_r)
    else $error("registers not zero after reset");
  chk_result_read_only: assert property (
    (wr_r && addr_r < adcr_pkg::ADDR_CTRL && !latch) |=> $stable(result_r) && $stable(flags_r))
    else $error("write altered a read-only register");
  chk_low_byte_layout: assert property (
    addr_r == adcr_pkg::ADDR_RES_LO |-> rd_data == {result_r[5:0], 1'b0, over_range_r})
    else $error("low result byte layout wrong");
  chk_high_byte_layout: assert property (
    addr_r == adcr_pkg::ADDR_RES_HI |-> rd_data == result_r[13:6])
    else $error("high result byte layout wrong");
  chk_over_range: assert property (
    latch |=> over_range_r == (|$past(conv_sample.amp_limit_flag_bits)))
    else $error("over-range flag does not follow limit flags");
  chk_flags_top_zero: assert property (
    addr_r == adcr_pkg::ADDR_LIMITS |-> rd_data[7:6] == 2'h0)
    else $error("limit register top bits not zero");
  chk_format_select: assert property (
    latch |=> result_r[13] == ($past(conv_sample.conv_result_bits[13]) ^
                               $past(ctrl_r.straight_binary_select))
              && flags_r == $past(conv_sample.amp_limit_flag_bits))
    else $error("result format or joint update wrong");
  chk_readback_armed: assert property (
    (latch && ctrl_r.readback_mode_select != 2'h0) |=> rb_pend_r)
    else $error("readback not armed after conversion");
  chk_start_timing: assert property (
    conv_start |-> $past(div_fall) && $past(falls_r) == 2'h1 && $past(cv_r) == adcr_pkg::CV_WAIT)
    else $error("conversion start not on second divided falling edge");
  chk_ctrl_reserved: assert property (
    ctrl_r.rsv_hi == 1'b0 && ctrl_r.rsv_mid == 1'b0 && !ctrl_r.rsv_lo)
    else $error("control reserved bits set");

  cov_conv_start: cover property (cmd_conv_r ##[1:200] conv_start);
  cov_readback: cover property (rb_pend_r ##1 phase_r == adcr_pkg::PH_RBK);
  cov_ctrl_write: cover property (wr_r && addr_r == adcr_pkg::ADDR_CTRL);
  cov_reg_read: cover property (phase_r == adcr_pkg::PH_RDATA);
endmodule

// ==== verification/adcr_host.sv ====
// host controller on the serial link; drives sclk, cs_n and din at the falling clk edge
module adcr_host (
  input  wire logic clk,
  input  wire logic lsb_first,
  input  wire logic dout,
  output logic      sclk,
  output logic      cs_n,
  output logic      din
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 5;  // clk cycles per serial half period, above the 3-cycle minimum

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b0;
  end

  // chip-select edge with setup on both sides; din flips so no stale level lingers
  task automatic select(input logic lvl);
    repeat (HALF) @(negedge clk);
    cs_n = lvl;
    din  = ~din;
    repeat (HALF) @(negedge clk);
  endtask

  // one byte each way: din moves while sclk is low, dout is taken at the active rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    int b;
    for (int i = 0; i < 8; i++) begin
      b = lsb_first ? i : 7 - i;
      din = tx[b];
      repeat (HALF) @(negedge clk);
      sclk = 1'b1;
      rx[b] = dout;
      repeat (HALF) @(negedge clk);
      sclk = 1'b0;
    end
  endtask
endmodule

// ==== verification/adc_result_and_control_regs_bench.sv ====
module adc_result_and_control_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [13:0] res;
    logic [5:0]  fl;
    logic [7:0]  ctrl;
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [7:0]  lim;
  } adcr_row_s;

  logic                  clk;
  logic                  rst_n;
  logic                  sclk;
  logic                  cs_n;
  logic                  din;
  logic                  lsb_first;
  logic                  conversion_clock_in;
  logic                  conv_done;
  adcr_pkg::adcr_sample_s conv_sample;
  logic                  dout;
  logic                  dout_oe;
  logic                  divided_converter_clock;
  logic                  conv_start;
  logic                  convert_busy_bit;
  int                    fail_count = 0;
  int                    compares = 0;
  logic [7:0]            d;
  logic [7:0]            e;
  int                    n;

  // ordinary cases: all four divisors, both formats, flags clear and set
  adcr_row_s rows [4] = '{
    '{14'h2ABC, 6'h00, 8'h00, 8'hF0, 8'hAA, 8'h00},
    '{14'h2ABC, 6'h21, 8'h21, 8'hF1, 8'h2A, 8'h21},
    '{14'h1FFF, 6'h3F, 8'h02, 8'hFD, 8'h7F, 8'h3F},
    '{14'h0000, 6'h00, 8'h23, 8'h00, 8'h80, 8'h00}
  };

  // clk at 20 MHz; conversion clock 1 MHz, its edges landing on clk falling edges
  // 1 MHz input keeps even the undivided converter clock below its 2.5 MHz ceiling
  initial begin
    clk = 1'b0;
    conversion_clock_in = 1'b0;
  end
  always #25 clk = ~clk;
  always #500 conversion_clock_in = ~conversion_clock_in;

  adcr_regs u_dut (
    .clk                     (clk),
    .rst_n                   (rst_n),
    .sclk                    (sclk),
    .cs_n                    (cs_n),
    .din                     (din),
    .lsb_first               (lsb_first),
    .conversion_clock_in     (conversion_clock_in),
    .conv_done               (conv_done),
    .conv_sample             (conv_sample),
    .dout                    (dout),
    .dout_oe                 (dout_oe),
    .divided_converter_clock (divided_converter_clock),
    .conv_start              (conv_start),
    .convert_busy_bit        (convert_busy_bit)
  );

  adcr_host u_host (
    .clk       (clk),
    .lsb_first (lsb_first),
    .dout      (dout),
    .sclk      (sclk),
    .cs_n      (cs_n),
    .din       (din)
  );

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one 16-bit write frame: instruction then data
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    logic [7:0] r;
    u_host.select(1'b0);
    u_host.xfer({3'h0, a}, r);
    u_host.xfer(v, r);
    u_host.select(1'b1);
  endtask

  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    logic [7:0] r;
    u_host.select(1'b0);
    u_host.xfer({3'h2, a}, r);
    u_host.xfer(8'h00, v);
    u_host.select(1'b1);
  endtask

  // divided clock period in clk cycles, edge to edge
  task automatic period(output int p);
    time t0;
    @(posedge divided_converter_clock);
    t0 = $time;
    @(posedge divided_converter_clock);
    p = int'(($time - t0) / 50);
  endtask

  // convert command, wait for the start pulse, then hand back a finished sample
  task automatic conv(input logic [13:0] res, input logic [5:0] fl);
    logic [7:0] r;
    int k;
    u_host.select(1'b0);
    u_host.xfer(8'h80, r);
    u_host.select(1'b1);
    k = 0;
    while (conv_start !== 1'b1 && k < 800) begin
      @(negedge clk);
      k++;
    end
    check({7'h0, conv_start}, 8'h01);
    @(negedge clk);
    check({7'h0, convert_busy_bit}, 8'h01);
    conv_done = 1'b1;
    conv_sample.conv_result_bits = res;
    conv_sample.amp_limit_flag_bits = fl;
    @(negedge clk);
    conv_done = 1'b0;
    repeat (3) @(negedge clk);
    check({7'h0, convert_busy_bit}, 8'h00);
  endtask

  // watchdog: the whole run needs well under this span
  initial begin
    #(100000 * 50);
    fail_count++;
    print_verdict();
  end

  initial begin
    rst_n = 1'b0;
    lsb_first = 1'b0;
    conv_done = 1'b0;
    conv_sample = '0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      wr(adcr_pkg::ADDR_CTRL, rows[i].ctrl);
      period(n);
      period(n);
      check(8'(n), 8'(20 << rows[i].ctrl[1:0]));
      conv(rows[i].res, rows[i].fl);
      rd(adcr_pkg::ADDR_RES_LO, d);
      check(d, rows[i].lo);
      rd(adcr_pkg::ADDR_RES_HI, d);
      check(d, rows[i].hi);
      rd(adcr_pkg::ADDR_LIMITS, d);
      check(d, rows[i].lim);
      rd(adcr_pkg::ADDR_CTRL, d);
      check(d, rows[i].ctrl);
    end
    // automatic readback: no instruction, byte order per mode, mode 3 high byte only
    for (int m = 1; m < 4; m++) begin
      wr(adcr_pkg::ADDR_CTRL, {4'h0, 2'(m), 2'h0});
      conv(14'h1234, 6'h00);
      u_host.select(1'b0);
      check({7'h0, dout_oe}, 8'h01);
      u_host.xfer(8'h00, d);
      e = (m == 2) ? 8'hD0 : 8'h48;
      check(d, e);
      if (m != 3) begin
        u_host.xfer(8'h00, d);
        e = (m == 1) ? 8'hD0 : 8'h48;
        check(d, e);
      end
      u_host.select(1'b1);
    end
    // read-only result, all writable control bits, reserved addresses
    wr(adcr_pkg::ADDR_RES_LO, 8'hFF);
    rd(adcr_pkg::ADDR_RES_LO, d);
    check(d, 8'hD0);
    // host keeps reserved control bits at zero; every writable bit set at once
    wr(adcr_pkg::ADDR_CTRL, 8'h2F);
    rd(adcr_pkg::ADDR_CTRL, d);
    check(d, 8'h2F);
    wr(adcr_pkg::ADDR_CTRL, 8'h00);
    rd(5'h0A, d);
    check(d, 8'h00);
    rd(5'h1F, d);
    check(d, 8'h00);
    // bit order reversed both ways must still give the same byte
    lsb_first = 1'b1;
    rd(adcr_pkg::ADDR_RES_HI, d);
    check(d, 8'h48);
    lsb_first = 1'b0;
    // second reset in mid-run clears everything
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    check({6'h0, dout_oe, convert_busy_bit}, 8'h00);
    rst_n = 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(5'(a), d);
      check(d, 8'h00);
    end
    print_verdict();
  end
endmodule
